/* File: rtl/aoi_audio_out.sv */
// audio output interface top: registers, voice buffer, source select
module aoi_audio_out (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // special function register port
  input  wire aoi_pkg::aoi_sfr_type  sfr,
  output logic [7:0]                 sfr_rdata,
  // interrupt
  input  wire logic                  global_audio_irq_enable,
  input  wire logic                  isr_entry,
  output logic                       audio_irq,
  // decoder word input
  input  wire logic                  dec_valid,
  input  wire logic [15:0]           dec_data,
  output logic                       dec_request,
  // master clock and dac pins
  input  wire logic                  pll_clk,
  output logic                       dac_system_clock_pin,
  output aoi_pkg::aoi_serial_type    dac_pins
);
  import aoi_pkg::*;

  typedef struct packed {
    aoi_fmt_type                         fmt;
    aoi_path_type                        path;
    logic [7:0]                          sample_reg;
    logic [AOI_VOICE_DEPTH-1:0][7:0]     vmem;
    logic [2:0]                          wp;
    logic [2:0]                          rp;
    logic [3:0]                          cnt;
    logic                                sample_request_flag;
    logic                                underrun_flag;
    logic                                buffer_full_flag;
    logic                                src_active;
    logic                                pending;
    logic                                have;
    logic [7:0]                          cur;
    logic [2:0]                          copies_left;
    logic                                side;
    logic                                clk_sync1;
    logic                                clk_sync2;
    logic                                clk_sync3;
    logic                                sys_clk;
    logic [7:0]                          rdata;
  } aoi_top_state_type;

  aoi_top_state_type st;
  aoi_top_state_type next_st;

  logic        en;
  logic        wr_data;
  logic        push;
  logic        pop;
  logic        src_now;
  logic        master_rise;
  logic        mp3_in_ready;
  logic        mp3_valid;
  logic [15:0] mp3_data;
  logic        mp3_ready;
  logic        mux_valid;
  logic [15:0] mux_data;
  logic        ob_in_ready;
  logic        ob_valid;
  logic [15:0] ob_data;
  logic        ser_ready;
  logic        voice_emit;

  // ==========================================================
  // decodes
  assign en          = st.path.interface_enable;
  assign wr_data     = sfr.wr & (sfr.addr == AOI_DATA_ADDR);
  assign push        = wr_data & en & (st.cnt != AOI_VOICE_FULL);
  assign pop         = en & st.path.source_select & !st.have & (st.cnt != 4'h0);
  assign master_rise = st.clk_sync2 & ~st.clk_sync3;
  assign voice_emit  = st.have & st.path.source_select & ob_in_ready;

  // ==========================================================
  // decoder buffer
  // request while room
  assign dec_request = mp3_in_ready & st.path.decoded_request_enable & en;

  aoi_word_buffer #(
    .WIDTH (16),
    .DEPTH (2)
  ) u_mp3_buffer (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .flush     (!en),
    .in_valid  (dec_valid & dec_request),
    .in_data   (dec_data),
    .in_ready  (mp3_in_ready),
    .out_valid (mp3_valid),
    .out_data  (mp3_data),
    .out_ready (mp3_ready)
  );

  // ==========================================================
  // source select
  // source mux
  assign mux_valid = st.path.source_select ? st.have : mp3_valid;
  assign mux_data  = st.path.source_select ? {st.cur, AOI_LOW_FILL} : mp3_data;
  assign mp3_ready = !st.path.source_select & ob_in_ready;

  aoi_word_buffer #(
    .WIDTH (16),
    .DEPTH (2)
  ) u_out_buffer (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .flush     (!en),
    .in_valid  (mux_valid),
    .in_data   (mux_data),
    .in_ready  (ob_in_ready),
    .out_valid (ob_valid),
    .out_data  (ob_data),
    .out_ready (ser_ready)
  );

  aoi_serializer u_serializer (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .enable      (en),
    .fmt         (st.fmt),
    .master_rise (master_rise),
    .word_valid  (ob_valid),
    .word_data   (ob_data),
    .word_ready  (ser_ready),
    .pins        (dac_pins),
    .running     ()
  );

  // ==========================================================
  // outputs
  // global enable gate
  assign audio_irq            = st.pending & global_audio_irq_enable;
  assign dac_system_clock_pin = st.sys_clk;
  assign sfr_rdata            = st.rdata;

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    src_now = 1'b0;

    // master clock synchroniser
    next_st.clk_sync1 = pll_clk;
    next_st.clk_sync2 = st.clk_sync1;
    next_st.clk_sync3 = st.clk_sync2;
    next_st.sys_clk   = en & st.clk_sync2;

    // register writes
    if (sfr.wr) begin
      if (sfr.addr == AOI_FMT_ADDR) begin
        next_st.fmt = aoi_fmt_type'(sfr.wdata);
      end else if (sfr.addr == AOI_PATH_ADDR) begin
        next_st.path          = aoi_path_type'(sfr.wdata);
        next_st.path.reserved = 1'b0;
      end else if (sfr.addr == AOI_DATA_ADDR) begin
        next_st.sample_reg = sfr.wdata;
      end
    end

    // register reads
    if (sfr.rd) begin
      if (sfr.addr == AOI_FMT_ADDR) begin
        next_st.rdata = st.fmt;
      end else if (sfr.addr == AOI_PATH_ADDR) begin
        next_st.rdata = st.path;
      end else if (sfr.addr == AOI_STAT_ADDR) begin
        next_st.rdata = {st.sample_request_flag, st.underrun_flag,
                         st.buffer_full_flag, 5'h00};
      end else if (sfr.addr == AOI_DATA_ADDR) begin
        next_st.rdata = st.sample_reg;
      end else begin
        next_st.rdata = 8'h00;
      end
    end

    // voice buffer
    if (push) begin
      next_st.vmem[st.wp] = sfr.wdata;
      next_st.wp          = st.wp + 3'h1;
    end
    if (pop) begin
      next_st.rp          = st.rp + 3'h1;
      next_st.cur         = st.vmem[st.rp];
      next_st.have        = 1'b1;
      next_st.side        = 1'b0;
      next_st.copies_left = AOI_DUP_EXTRA[st.path.duplication_factor];
    end
    next_st.cnt = st.cnt + {3'h0, push} - {3'h0, pop};

    // each copy goes out twice, left then right
    if (voice_emit) begin
      next_st.side = ~st.side;
      if (st.side) begin
        if (st.copies_left == 3'h0) begin
          next_st.have = 1'b0;
        end else begin
          next_st.copies_left = st.copies_left - 3'h1;
        end
      end
    end

    if (wr_data) begin
      next_st.sample_request_flag = 1'b0;
      next_st.underrun_flag       = 1'b0;
    end
    if (st.cnt == AOI_SAMPLE_REQUEST_FLAG_LEVEL && push && !pop) begin
      next_st.sample_request_flag = 1'b0;
    end
    if (st.cnt == AOI_SAMPLE_REQUEST_FLAG_LEVEL && pop && !push) begin
      next_st.sample_request_flag = 1'b1;
    end
    if (st.cnt == 4'h1 && pop && !push) begin
      next_st.underrun_flag = 1'b1;
    end
    next_st.buffer_full_flag = (next_st.cnt == AOI_VOICE_FULL);

    src_now = st.path.source_select &
              ((st.sample_request_flag & ~st.path.sample_request_mask) |
               (st.underrun_flag & ~st.path.underrun_mask));
    next_st.src_active = src_now;
    if (isr_entry) begin
      next_st.pending = 1'b0;
    end
    if (src_now && !st.src_active) begin
      next_st.pending = 1'b1;
    end

    if (!next_st.path.interface_enable) begin
      next_st.wp   = '0;
      next_st.rp   = '0;
      next_st.cnt  = '0;
      next_st.have = 1'b0;
      next_st.buffer_full_flag = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st            <= '0;
      st.fmt        <= aoi_fmt_type'(AOI_FMT_RESET);
      st.path       <= aoi_path_type'(AOI_PATH_RESET);
      st.sample_reg <= AOI_DATA_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule

/* File: common/aoi_pkg.sv */
// audio output interface: register map, field layouts and shared types
package aoi_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] AOI_FMT_ADDR   = 8'h9a;
  localparam logic [7:0] AOI_PATH_ADDR  = 8'h9b;
  localparam logic [7:0] AOI_STAT_ADDR  = 8'h9c;
  localparam logic [7:0] AOI_DATA_ADDR  = 8'h9d;

  // ==========================================================
  // reset values
  localparam logic [7:0] AOI_FMT_RESET  = 8'h08;
  localparam logic [7:0] AOI_PATH_RESET = 8'hb2;
  localparam logic [7:0] AOI_DATA_RESET = 8'hff;

  // ==========================================================
  // voice buffer geometry and thresholds
  localparam int         AOI_VOICE_DEPTH = 8;
  localparam logic [3:0] AOI_VOICE_FULL  = 4'h8;
  localparam logic [3:0] AOI_SAMPLE_REQUEST_FLAG_LEVEL  = 4'h4;
  localparam logic [7:0] AOI_LOW_FILL    = 8'h00;

  // ==========================================================
  // extra copies per sample, indexed by the duplication field
  localparam logic [2:0] AOI_DUP_EXTRA [4] = '{3'h0, 3'h1, 3'h3, 3'h5};

  // ==========================================================
  // master clock edges per bit clock half period, and last bit index of a slot
  localparam logic [2:0] AOI_HALF_256_16 = 3'h4;
  localparam logic [2:0] AOI_HALF_256_32 = 3'h2;
  localparam logic [2:0] AOI_HALF_384_16 = 3'h6;
  localparam logic [2:0] AOI_HALF_384_32 = 3'h3;
  localparam logic [4:0] AOI_SLOT_LAST_16 = 5'h0f;
  localparam logic [4:0] AOI_SLOT_LAST_32 = 5'h1f;

  // ==========================================================
  // register layouts
  typedef struct packed {
    logic [4:0] justification_field;
    logic       word_select_polarity;
    logic       frame_size_select;
    logic       master_rate_select;
  } aoi_fmt_type;

  typedef struct packed {
    logic       source_select;
    logic       decoded_request_enable;
    logic       sample_request_mask;
    logic       underrun_mask;
    logic       reserved;
    logic [1:0] duplication_factor;
    logic       interface_enable;
  } aoi_path_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aoi_sfr_type;

  typedef struct packed {
    logic bit_clock_pin;
    logic word_select_pin;
    logic serial_data_pin;
  } aoi_serial_type;

endpackage

/* File: rtl/aoi_word_buffer.sv */
// small word fifo with valid and ready on both sides
module aoi_word_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  import aoi_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } aoi_buf_state_type;

  aoi_buf_state_type st;
  aoi_buf_state_type next_st;
  logic              push;
  logic              pop;

  // ==========================================================
  // handshakes
  assign in_ready  = (st.cnt != FULL);
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    if (flush) begin
      next_st.wp  = '0;
      next_st.rp  = '0;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

/* File: rtl/aoi_serializer.sv */
// bit clock, word select and serial data generator
module aoi_serializer (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // control
  input  wire logic            enable,
  input  wire aoi_pkg::aoi_fmt_type fmt,
  input  wire logic            master_rise,
  // word input
  input  wire logic            word_valid,
  input  wire logic [15:0]     word_data,
  output logic                 word_ready,
  // pins
  output aoi_pkg::aoi_serial_type pins,
  output logic                 running
);
  import aoi_pkg::*;

  typedef struct packed {
    logic           running;
    logic           side;
    logic [2:0]     half_cnt;
    logic [4:0]     bit_cnt;
    logic [15:0]    cur;
    logic [15:0]    prev;
    aoi_serial_type pins;
  } aoi_ser_state_type;

  aoi_ser_state_type st;
  aoi_ser_state_type next_st;
  logic [2:0]        half;
  logic [4:0]        slot_last;
  logic              fall;
  logic              slot_start;

  function automatic logic pick_bit(input logic [4:0] bc, input logic [4:0] just,
                                    input logic [4:0] last, input logic [15:0] cur,
                                    input logic [15:0] prev);
    logic [5:0] pos;
    logic [15:0] w;
    pos = 6'h00;
    w   = cur;
    if (bc >= just) begin
      pos = {1'b0, bc} - {1'b0, just};
    end else begin
      pos = {1'b0, bc} + {1'b0, last} + 6'h01 - {1'b0, just};
      w   = prev;
    end
    pick_bit = (pos < 6'h10) ? w[4'hf - pos[3:0]] : 1'b0;
  endfunction

  // ==========================================================
  // bit clock ratio from master rate and frame size
  // rate and frame size bits pick ratio
  always_comb begin
    if (fmt.master_rate_select) begin
      half = fmt.frame_size_select ? AOI_HALF_384_32 : AOI_HALF_384_16;
    end else begin
      half = fmt.frame_size_select ? AOI_HALF_256_32 : AOI_HALF_256_16;
    end
  end

  assign slot_last  = fmt.frame_size_select ? AOI_SLOT_LAST_32 : AOI_SLOT_LAST_16;
  assign fall       = st.running & master_rise & (st.half_cnt == half - 3'h1)
                      & st.pins.bit_clock_pin;
  assign slot_start = fall & (st.bit_cnt == slot_last);
  assign word_ready = enable & (!st.running | slot_start);
  assign pins       = st.pins;
  assign running    = st.running;

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st = '0;
    end else if (!st.running) begin
      if (word_valid) begin
        next_st.running  = 1'b1;
        next_st.cur      = word_data;
        next_st.prev     = '0;
        next_st.bit_cnt  = '0;
        next_st.side     = 1'b0;
        next_st.half_cnt = '0;
      end
    end else if (master_rise) begin
      if (st.half_cnt == half - 3'h1) begin
        next_st.half_cnt = '0;
        next_st.pins.bit_clock_pin = ~st.pins.bit_clock_pin;
        if (st.pins.bit_clock_pin) begin
          if (slot_start) begin
            next_st.bit_cnt = '0;
            next_st.side    = ~st.side;
            next_st.prev    = st.cur;
            next_st.cur     = word_valid ? word_data : 16'h0000;
          end else begin
            next_st.bit_cnt = st.bit_cnt + 5'h01;
          end
        end
      end else begin
        next_st.half_cnt = st.half_cnt + 3'h1;
      end
    end
    if (next_st.running) begin
      next_st.pins.word_select_pin = fmt.word_select_polarity ? ~next_st.side
                                                               : next_st.side;
      next_st.pins.serial_data_pin = pick_bit(next_st.bit_cnt, fmt.justification_field,
                                              slot_last, next_st.cur, next_st.prev);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

/* File: dv/aoi_audio_out_properties.sv */
// assertions on the audio output interface top ports
module aoi_chk (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // register port and interrupt
  input wire aoi_pkg::aoi_sfr_type    sfr,
  input wire logic [7:0]              sfr_rdata,
  input wire logic                    global_audio_irq_enable,
  input wire logic                    isr_entry,
  input wire logic                    audio_irq,
  // decoder and dac side
  input wire logic                    dec_request,
  input wire logic                    dac_system_clock_pin,
  input wire aoi_pkg::aoi_serial_type dac_pins
);
  import aoi_pkg::*;
  // ======
  // register shadows
  aoi_path_type path_q;
  aoi_fmt_type  fmt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      path_q <= AOI_PATH_RESET;
      fmt_q  <= AOI_FMT_RESET;
    end else if (sfr.wr && sfr.addr == AOI_PATH_ADDR) begin
      path_q <= sfr.wdata;
    end else if (sfr.wr && sfr.addr == AOI_FMT_ADDR) begin
      fmt_q <= sfr.wdata;
    end
  end
  // ======
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_irq_global_gate: assert property (audio_irq |-> global_audio_irq_enable)
    else $error("irq without global enable");
  a_request_pause: assert property (!path_q.decoded_request_enable |-> !dec_request)
    else $error("request while paused");
  a_sysclk_off: assert property (!path_q.interface_enable [*2] |-> !dac_system_clock_pin)
    else $error("system clock while disabled");
  a_bitclk_still: assert property (!path_q.interface_enable [*2] |-> !dac_pins.bit_clock_pin)
    else $error("bit clock while disabled");
  a_format_readback: assert property (sfr.rd && sfr.addr == AOI_FMT_ADDR |=>
    sfr_rdata == $past(fmt_q)) else $error("format control read wrong");
  a_data_on_fall: assert property ($rose(dac_pins.bit_clock_pin) |->
    $stable(dac_pins.serial_data_pin) && $stable(dac_pins.word_select_pin))
    else $error("data moved on bit clock rise");
  a_isr_clears: assert property (isr_entry && !path_q.source_select |=> !audio_irq)
    else $error("pending kept after service entry");
  a_sample_clears: assert property (!path_q.source_select && sfr.wr &&
    sfr.addr == AOI_DATA_ADDR ##2 sfr.rd && sfr.addr == AOI_STAT_ADDR |=>
    sfr_rdata[7:6] == 2'b00) else $error("flags kept after sample write");
endmodule
bind aoi_audio_out aoi_chk i_aoi_chk (.mclk(mclk), .rst_n(rst_n), .sfr(sfr),
  .sfr_rdata(sfr_rdata), .global_audio_irq_enable(global_audio_irq_enable),
  .isr_entry(isr_entry), .audio_irq(audio_irq), .dec_request(dec_request),
  .dac_system_clock_pin(dac_system_clock_pin), .dac_pins(dac_pins));

/* File: dv/aoi_dac_model.sv */
// behavioural audio dac capturing left and right words
module aoi_dac_model (
  // serial pins and dac setup
  input  wire aoi_pkg::aoi_serial_type pins,
  input  wire aoi_pkg::aoi_fmt_type    fmt,
  // captured words
  output logic [15:0]                  left_word,
  output logic [15:0]                  right_word,
  output logic [15:0]                  word_cnt,
  output logic [15:0]                  rise_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  import aoi_pkg::*;
  logic [31:0] shift;
  logic [15:0] word;
  logic        last_ws;
  initial begin
    {left_word, right_word, word_cnt, rise_cnt, shift, last_ws} = '0;
  end
  // word of the finished slot from size and offset
  assign word = 16'(shift >> ((fmt.frame_size_select ? 5'h10 : 5'h00)
                              - fmt.justification_field));
  // msb first, left side from polarity
  always @(posedge pins.bit_clock_pin) begin
    rise_cnt <= rise_cnt + 16'h0001;
    last_ws  <= pins.word_select_pin;
    shift    <= {shift[30:0], pins.serial_data_pin};
    if (pins.word_select_pin != last_ws) begin
      word_cnt <= word_cnt + 16'h0001;
      if (last_ws == fmt.word_select_polarity) left_word <= word;
      else right_word <= word;
    end
  end
endmodule

/* File: dv/tb_audio_output_interface.sv */
// self-checking bench for the audio output interface
module tb_audio_output_interface;
  timeunit 1ns;
  timeprecision 1ps;
  import aoi_pkg::*;
  typedef struct packed {logic w; logic [7:0] wa, wd, ra, exp;} aoi_row_type;
  // ======
  // stimulus and wiring
  logic           mclk = 1'b0;
  logic           rst_n = 1'b0;
  logic           pll_clk = 1'b0;
  logic           global_audio_irq_enable = 1'b0;
  logic           isr_entry = 1'b0;
  logic           dec_valid = 1'b0;
  logic           sel = 1'b0;
  aoi_sfr_type    sfr = '0;
  logic [7:0]     sfr_rdata;
  logic           audio_irq;
  logic           dec_request;
  logic           dac_system_clock_pin;
  logic [15:0]    dec_data;
  aoi_serial_type dac_pins;
  logic [15:0]    left_word, right_word, word_cnt, rise_cnt;
  logic [15:0]    rise_mark;
  aoi_fmt_type    dac_fmt = 8'h04;
  int             error_cnt = 0;
  int             tests_run = 0;
  int             cyc = 0;
  localparam aoi_row_type ROWS [10] = '{
    '{1'b0, 8'h00, 8'h00, 8'h9a, 8'h08}, '{1'b0, 8'h00, 8'h00, 8'h9b, 8'hb2},
    '{1'b0, 8'h00, 8'h00, 8'h9c, 8'h00}, '{1'b0, 8'h00, 8'h00, 8'h9d, 8'hff},
    '{1'b0, 8'h00, 8'h00, 8'h50, 8'h00}, '{1'b1, 8'h9c, 8'hff, 8'h9c, 8'h00},
    '{1'b1, 8'h9b, 8'h7e, 8'h9b, 8'h76}, '{1'b1, 8'h9d, 8'h5a, 8'h9c, 8'h00},
    '{1'b0, 8'h00, 8'h00, 8'h9d, 8'h5a}, '{1'b1, 8'h9a, 8'h04, 8'h9a, 8'h04}};
  assign dec_data = sel ? 16'h3c5a : 16'ha5c3;
  always #12.5 mclk = ~mclk;
  initial #7 forever #100 pll_clk = ~pll_clk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (!dec_valid) sel <= 1'b0;
    else if (dec_request) sel <= ~sel;
    if (cyc == 80000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  aoi_audio_out i_aoi_audio_out (.mclk(mclk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .global_audio_irq_enable(global_audio_irq_enable), .isr_entry(isr_entry),
    .audio_irq(audio_irq), .dec_valid(dec_valid), .dec_data(dec_data),
    .dec_request(dec_request), .pll_clk(pll_clk),
    .dac_system_clock_pin(dac_system_clock_pin), .dac_pins(dac_pins));
  aoi_dac_model i_aoi_dac_model (.pins(dac_pins), .fmt(dac_fmt), .left_word(left_word),
    .right_word(right_word), .word_cnt(word_cnt), .rise_cnt(rise_cnt));
  // ======
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    sfr <= '0;
    #1;
  endtask
  task automatic stat(input logic [7:0] exp);
    acc(1'b0, 8'h9c, 8'h00);
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask
  task automatic isr();
    @(posedge mclk);
    isr_entry <= 1'b1;
    @(posedge mclk);
    isr_entry <= 1'b0;
    #1;
    chk({15'h0000, audio_irq}, 16'h0000);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 40000 && audio_irq !== 1'b1; i++) @(posedge mclk);
    #1;
    chk({15'h0000, audio_irq}, 16'h0001);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ======
  // sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) acc(1'b1, ROWS[i].wa, ROWS[i].wd);
      acc(1'b0, ROWS[i].ra, 8'h00);
      chk({8'h00, sfr_rdata}, {8'h00, ROWS[i].exp});
    end
    acc(1'b1, 8'h9b, 8'h01);
    repeat (400) @(posedge mclk);
    chk(rise_cnt, 16'h0000);
    dec_valid <= 1'b1;
    acc(1'b1, 8'h9b, 8'h41);
    for (int i = 0; i < 20000 && word_cnt < 16'h0005; i++) @(posedge mclk);
    chk(left_word, 16'ha5c3);
    chk(right_word, 16'h3c5a);
    dec_valid <= 1'b0;
    acc(1'b1, 8'h9b, 8'h00);
    acc(1'b1, 8'h9a, 8'h0b);
    dac_fmt <= 8'h0b;
    @(posedge mclk) dec_valid <= 1'b1;
    acc(1'b1, 8'h9b, 8'h41);
    for (int i = 0; i < 20000 && word_cnt < 16'h000b; i++) @(posedge mclk);
    chk(left_word, 16'ha5c3);
    chk(right_word, 16'h3c5a);
    isr();
    acc(1'b1, 8'h9b, 8'h01);
    chk({15'h0000, dec_request}, 16'h0000);
    acc(1'b1, 8'h9b, 8'h00);
    @(posedge mclk) global_audio_irq_enable <= 1'b1;
    acc(1'b1, 8'h9b, 8'h81);
    for (int i = 0; i < 12; i++) acc(1'b1, 8'h9d, 8'h40 + 8'(i));
    stat(8'h20);
    isr();
    wait_irq();
    stat(8'h80);
    chk({left_word[7:0], right_word[7:0]}, 16'h0000);
    chk({12'h000, left_word[15:12]}, 16'h0004);
    isr();
    acc(1'b1, 8'h9b, 8'ha1);
    for (int i = 0; i < 4; i++) acc(1'b1, 8'h9d, 8'h50 + 8'(i));
    stat(8'h00);
    wait_irq();
    stat(8'hc0);
    @(posedge mclk) rst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rise_mark = rise_cnt;
    stat(8'h00);
    acc(1'b0, 8'h9a, 8'h00);
    chk({8'h00, sfr_rdata}, 16'h0008);
    repeat (400) @(posedge mclk);
    chk(rise_cnt, rise_mark);
    tally_and_finish();
  end
endmodule
